// ---- audio_rx_defines.vh ----
// Constants for the audio receive decoder, receive FIFO and interrupt logic
`ifndef AUDIO_RX_DEFINES_VH
`define AUDIO_RX_DEFINES_VH

// Receive FIFO geometry: eight stereo pairs
`define RX_FIFO_DEPTH      8
`define RX_FIFO_PTR_W      3
`define RX_FIFO_CNT_W      4
`define RX_FIFO_FULL_CNT   4'h8
`define RX_PAIR_W          64
`define RX_SAMPLE_W        32

// Master bit clock: toggles every two master clock rising edges (MCLK / 4)
`define MCLK_EDGES_PER_HALF 1'b1

// Interrupt status bit positions
`define IRQ_TX_SERVICE     0
`define IRQ_TX_WRITE_ERR   1
`define IRQ_RX_SERVICE     2
`define IRQ_RX_READ_ERR    3
`define IRQ_W              4

// Reset values
`define RST_STATUS         4'h0
`define RST_SAMPLE         32'h0000_0000
`define RST_LEVEL          5'h00
`define RST_BIT_IDX        6'h00

`endif

// ---- audio_rx_irq.v ----
// Audio serial receiver with FIFO, read modes, clocking, interrupts and DMA requests
//
// Behaviour
// - One interrupt line from any unmasked source
// - Transmit service and write error, each maskable
// - Transmit service while level below limit, enabled
// - Transmit write error sticky until cleared
// - Burst DMA requests only, gated by enable
// - I2S, left and right justified, MSB first
// - Configurable sample and slot sizes, slot larger
// - Bits after sample LSB stored as zero
// - Full FIFO drops incoming sample pairs
// - Decoder runs only while receive enabled
// - Eight pairs, MSB aligned, left then right
// - Plain, compact 16 and compact 8 reads
// - Mono reads return the selected channel
// - Fill level reports two per entry
// - Bit clock master at MCLK/4, optional inversion
// - Receive service and read error, each maskable
// - Receive service while level above limit, enabled
// - Empty or misordered read sets read error
`include "audio_rx_defines.vh"

module audio_rx_irq (
  input  wire          core_clk,
  input  wire          arst_n,
  input  wire          rx_engine_enable,
  input  wire          rx_mclk_external,
  input  wire          sclk_master_sel,
  input  wire          sclk_invert,
  input  wire          justify_right,
  input  wire          data_delay,
  input  wire          ws_polarity,
  input  wire [5:0]    sample_bits,
  input  wire [5:0]    slot_bits,
  input  wire          rx_read_mode,
  input  wire          compact_size,
  input  wire          mono_fifo_select,
  input  wire          channel_select,
  input  wire          rx_fifo_req_enable,
  input  wire          tx_fifo_req_enable,
  input  wire [4:0]    rx_limit,
  input  wire [4:0]    tx_limit,
  input  wire [4:0]    tx_fill_level,
  input  wire          tx_write_full_attempt,
  input  wire [3:0]    irq_mask,
  input  wire [3:0]    irq_clear,
  input  wire          rx_fifo_rd,
  input  wire          rx_fifo_rd_right,
  input  wire          int_mclk,
  input  wire          rx_master_clock_pin_i,
  output wire          rx_master_clock_pin_o,
  output wire          rx_master_clock_pin_oe_n,
  input  wire          rx_bit_clock_pin_i,
  output wire          rx_bit_clock_pin_o,
  output wire          rx_bit_clock_pin_oe_n,
  input  wire          rx_ws_pin_i,
  output wire          rx_ws_pin_o,
  output wire          rx_ws_pin_oe_n,
  input  wire          rx_data_pin_i,
  output reg  [31:0]   rx_fifo_data_r,
  output wire          rx_next_is_right,
  output wire [4:0]    rx_fill_level,
  output reg  [3:0]    raw_status_r,
  output reg  [3:0]    masked_status_r,
  output reg           irq_r,
  output reg           tx_dma_burst_req_r,
  output reg           rx_dma_burst_req_r
);

  // Synchroniser stages for pin and foreign-clock inputs
  reg  [1:0]  ext_mclk_s_r;
  reg  [1:0]  int_mclk_s_r;
  reg  [1:0]  sclk_s_r;
  reg  [1:0]  ws_s_r;
  reg  [1:0]  sd_s_r;

  reg         mclk_prev_r;
  reg         mclk_cnt_r;
  reg         sclk_gen_r;
  reg         ws_gen_r;
  reg  [5:0]  ws_cnt_r;
  reg         sclk_eff_prev_r;

  reg         ws_prev_r;
  reg  [5:0]  bit_idx_r;
  reg  [31:0] shift_r;
  reg  [31:0] left_r;
  reg         left_ok_r;
  reg         next_right_r;
  reg         tx_err_r;
  reg         rx_err_r;

  wire        mclk_sel;
  wire        mclk_rise;
  wire        sclk_eff;
  wire        sample_evt;
  wire        ws_in;
  wire        ws_change;
  wire        prev_was_right;
  wire [5:0]  cur_idx;
  wire [5:0]  lead;
  wire [6:0]  pos;
  wire        in_win;
  wire [31:0] shift_base;
  wire [31:0] shift_nxt;
  wire        push;
  wire [63:0] head_pair;
  wire [31:0] head_left;
  wire [31:0] head_right;
  wire        fifo_full;
  wire        fifo_empty;
  wire [3:0]  fifo_count;
  reg         pop;
  reg  [31:0] rd_data_nxt;
  reg         rd_load;
  reg         rd_err_evt;
  reg         next_right_nxt;
  wire        tx_service;
  wire        rx_service;
  wire [3:0]  raw_nxt;

  // Two-flop synchronisers; first stage feeds only the second
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_mclk_s_r <= 2'b00;
      int_mclk_s_r <= 2'b00;
      sclk_s_r     <= 2'b00;
      ws_s_r       <= 2'b00;
      sd_s_r       <= 2'b00;
    end else begin
      ext_mclk_s_r <= {ext_mclk_s_r[0], rx_master_clock_pin_i};
      int_mclk_s_r <= {int_mclk_s_r[0], int_mclk};
      sclk_s_r     <= {sclk_s_r[0], rx_bit_clock_pin_i};
      ws_s_r       <= {ws_s_r[0], rx_ws_pin_i};
      sd_s_r       <= {sd_s_r[0], rx_data_pin_i};
    end
  end

  // Master clock source select
  assign mclk_sel  = rx_mclk_external ? ext_mclk_s_r[1] : int_mclk_s_r[1];
  assign mclk_rise = mclk_sel & ~mclk_prev_r;

  // Internal master clock is driven out when not taken from outside
  assign rx_master_clock_pin_o    = int_mclk_s_r[1];
  assign rx_master_clock_pin_oe_n = rx_mclk_external;

  // Bit clock and word select generation as master
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mclk_prev_r <= 1'b0;
      mclk_cnt_r  <= 1'b0;
      sclk_gen_r  <= 1'b0;
      ws_gen_r    <= 1'b0;
      ws_cnt_r    <= `RST_BIT_IDX;
    end else begin
      mclk_prev_r <= mclk_sel;
      if (!sclk_master_sel || !rx_engine_enable) begin
        mclk_cnt_r <= 1'b0;
        sclk_gen_r <= 1'b0;
        ws_gen_r   <= 1'b0;
        ws_cnt_r   <= `RST_BIT_IDX;
      end else if (mclk_rise) begin
        mclk_cnt_r <= ~mclk_cnt_r;
        if (mclk_cnt_r == `MCLK_EDGES_PER_HALF) begin
          sclk_gen_r <= ~sclk_gen_r;
          if (sclk_gen_r) begin
            // Word select changes on the falling bit clock edge
            if (ws_cnt_r >= slot_bits - 6'd1) begin
              ws_cnt_r <= `RST_BIT_IDX;
              ws_gen_r <= ~ws_gen_r;
            end else begin
              ws_cnt_r <= ws_cnt_r + 6'd1;
            end
          end
        end
      end
    end
  end

  // Pin drive: low enable while this end masters the bit clock
  assign rx_bit_clock_pin_o    = sclk_gen_r ^ sclk_invert;
  assign rx_bit_clock_pin_oe_n = ~sclk_master_sel;
  assign rx_ws_pin_o           = ws_gen_r;
  assign rx_ws_pin_oe_n        = ~sclk_master_sel;

  // Sampling edge of the effective bit clock
  assign sclk_eff   = sclk_master_sel ? sclk_gen_r : (sclk_s_r[1] ^ sclk_invert);
  assign sample_evt = sclk_eff & ~sclk_eff_prev_r & rx_engine_enable;
  assign ws_in      = sclk_master_sel ? ws_gen_r : ws_s_r[1];

  // Slot position and window of the sample within it
  assign ws_change      = ws_in ^ ws_prev_r;
  assign prev_was_right = ws_prev_r ^ ws_polarity;
  assign cur_idx        = ws_change ? 6'd0 : bit_idx_r;
  assign lead           = justify_right ? (slot_bits - sample_bits) : {5'd0, data_delay};
  assign pos            = {1'b0, cur_idx} - {1'b0, lead};
  assign in_win         = (cur_idx >= lead) && (pos < {1'b0, sample_bits});
  assign shift_base     = ws_change ? `RST_SAMPLE : shift_r;
  assign shift_nxt      = (in_win && sd_s_r[1]) ?
                          (shift_base | (32'h8000_0000 >> pos[4:0])) : shift_base;

  // Completed right slot pushes the pair, or drops it when full
  assign push = sample_evt & ws_change & prev_was_right & left_ok_r & ~fifo_full;

  // Serial decoder
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_eff_prev_r <= 1'b0;
      ws_prev_r       <= 1'b0;
      bit_idx_r       <= `RST_BIT_IDX;
      shift_r         <= `RST_SAMPLE;
      left_r          <= `RST_SAMPLE;
      left_ok_r       <= 1'b0;
    end else begin
      sclk_eff_prev_r <= sclk_eff;
      if (!rx_engine_enable) begin
        left_ok_r <= 1'b0;
        bit_idx_r <= `RST_BIT_IDX;
        ws_prev_r <= ws_in;
      end else if (sample_evt) begin
        ws_prev_r <= ws_in;
        shift_r   <= shift_nxt;
        if (cur_idx != 6'h3f) begin
          bit_idx_r <= cur_idx + 6'd1;
        end
        if (ws_change) begin
          if (!prev_was_right) begin
            left_r    <= shift_r;
            left_ok_r <= 1'b1;
          end else begin
            left_ok_r <= 1'b0;
          end
        end
      end
    end
  end

  // Receive FIFO of pairs
  rx_pair_fifo u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .push      (push),
    .push_pair ({left_r, shift_r}),
    .pop       (pop),
    .head_pair (head_pair),
    .full      (fifo_full),
    .empty     (fifo_empty),
    .count     (fifo_count)
  );

  assign head_left        = head_pair[63:32];
  assign head_right       = head_pair[31:0];
  assign rx_fill_level    = {fifo_count, 1'b0};
  assign rx_next_is_right = next_right_r;

  // Read-mode decode for a software or DMA read
  always @* begin
    pop            = 1'b0;
    rd_load        = 1'b0;
    rd_err_evt     = 1'b0;
    rd_data_nxt    = rx_fifo_data_r;
    next_right_nxt = next_right_r;
    if (rx_fifo_rd) begin
      if (fifo_empty) begin
        rd_err_evt = 1'b1;
      end else if (rx_read_mode) begin
        pop     = 1'b1;
        rd_load = 1'b1;
        if (compact_size) begin
          rd_data_nxt = {16'h0000, head_right[31:24], head_left[31:24]};
        end else begin
          rd_data_nxt = {head_right[31:16], head_left[31:16]};
        end
      end else if (mono_fifo_select) begin
        pop         = 1'b1;
        rd_load     = 1'b1;
        rd_data_nxt = channel_select ? head_right : head_left;
      end else if (rx_fifo_rd_right != next_right_r) begin
        rd_err_evt = 1'b1;
      end else begin
        rd_load        = 1'b1;
        rd_data_nxt    = next_right_r ? head_right : head_left;
        pop            = next_right_r;
        next_right_nxt = ~next_right_r;
      end
    end
  end

  // Read data register and pair-order tracking
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_fifo_data_r <= `RST_SAMPLE;
      next_right_r   <= 1'b0;
    end else begin
      if (rd_load) begin
        rx_fifo_data_r <= rd_data_nxt;
      end
      if (rx_read_mode || mono_fifo_select) begin
        next_right_r <= 1'b0;
      end else begin
        next_right_r <= next_right_nxt;
      end
    end
  end

  // Service request levels against limits
  assign tx_service = (tx_fill_level < tx_limit) & tx_fifo_req_enable;
  assign rx_service = (rx_fill_level > rx_limit) & rx_fifo_req_enable;

  // Sticky error flags; a new event wins over a clear
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_err_r <= 1'b0;
      rx_err_r <= 1'b0;
    end else begin
      if (tx_write_full_attempt) begin
        tx_err_r <= 1'b1;
      end else if (irq_clear[`IRQ_TX_WRITE_ERR]) begin
        tx_err_r <= 1'b0;
      end
      if (rd_err_evt) begin
        rx_err_r <= 1'b1;
      end else if (irq_clear[`IRQ_RX_READ_ERR]) begin
        rx_err_r <= 1'b0;
      end
    end
  end

  // Raw status vector; error bits carry the flag's next value
  assign raw_nxt[`IRQ_TX_SERVICE]   = tx_service;
  assign raw_nxt[`IRQ_TX_WRITE_ERR] = tx_write_full_attempt |
                                      (tx_err_r & ~irq_clear[`IRQ_TX_WRITE_ERR]);
  assign raw_nxt[`IRQ_RX_SERVICE]   = rx_service;
  assign raw_nxt[`IRQ_RX_READ_ERR]  = rd_err_evt |
                                      (rx_err_r & ~irq_clear[`IRQ_RX_READ_ERR]);

  // Status, masking, interrupt line and burst DMA requests
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_status_r       <= `RST_STATUS;
      masked_status_r    <= `RST_STATUS;
      irq_r              <= 1'b0;
      tx_dma_burst_req_r <= 1'b0;
      rx_dma_burst_req_r <= 1'b0;
    end else begin
      raw_status_r       <= raw_nxt;
      masked_status_r    <= raw_nxt & irq_mask;
      irq_r              <= |(raw_nxt & irq_mask);
      tx_dma_burst_req_r <= tx_service;
      rx_dma_burst_req_r <= rx_service;
    end
  end

endmodule

// ---- audio_rx_irq_asserts.sv ----
// Checker for the audio receiver status, request and pin outputs
module audio_rx_irq_chk (
  input logic       core_clk,
  input logic       arst_n,
  input logic [3:0] irq_mask,
  input logic [3:0] irq_clear,
  input logic       tx_write_full_attempt,
  input logic [4:0] tx_fill_level,
  input logic [4:0] tx_limit,
  input logic [4:0] rx_limit,
  input logic       tx_fifo_req_enable,
  input logic       rx_fifo_req_enable,
  input logic       rx_fifo_rd,
  input logic       sclk_master_sel,
  input logic       rx_bit_clock_pin_oe_n,
  input logic [4:0] rx_fill_level,
  input logic [3:0] raw_status_r,
  input logic [3:0] masked_status_r,
  input logic       irq_r,
  input logic       tx_dma_burst_req_r,
  input logic       rx_dma_burst_req_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Status, interrupt line and requests
  irq_or_a: assert property (irq_r == |masked_status_r)
    else $error("irq line not OR of masked status");
  mask_and_a: assert property (masked_status_r == (raw_status_r & $past(irq_mask)))
    else $error("masked status not raw and mask");
  err_set_a: assert property (tx_write_full_attempt |=> raw_status_r[1])
    else $error("write error not set");
  err_hold_a: assert property (raw_status_r[1] && !irq_clear[1] |=> raw_status_r[1])
    else $error("write error lost");
  err_clr_a: assert property (raw_status_r[1] && irq_clear[1] && !tx_write_full_attempt
    |=> !raw_status_r[1])
    else $error("write error not cleared");
  tx_svc_a: assert property ((tx_fill_level < tx_limit) && irq_mask[0] && tx_fifo_req_enable
    |=> raw_status_r[0])
    else $error("tx service missing");
  tx_svc_off_a: assert property (tx_fill_level >= tx_limit |=> !raw_status_r[0])
    else $error("tx service at or above limit");
  rx_svc_a: assert property ((rx_fill_level > rx_limit) && irq_mask[2] && rx_fifo_req_enable
    |=> raw_status_r[2])
    else $error("rx service missing");
  rd_empty_a: assert property (rx_fifo_rd && rx_fill_level == 5'h00 |=> raw_status_r[3])
    else $error("empty read not flagged");
  dma_gate_a: assert property ((tx_dma_burst_req_r |-> $past(tx_fifo_req_enable))
    and (rx_dma_burst_req_r |-> $past(rx_fifo_req_enable)))
    else $error("dma request without enable");
  level_a: assert property (rx_fill_level <= 5'h10 && !rx_fill_level[0])
    else $error("rx level out of range");
  sck_oe_a: assert property (rx_bit_clock_pin_oe_n == !sclk_master_sel)
    else $error("bit clock enable wrong");
  // Main scenarios
  irq_c: cover property ($rose(irq_r));
  rd_err_c: cover property ($rose(raw_status_r[3]));
  rx_dma_c: cover property (rx_dma_burst_req_r);
endmodule

// ---- codec_tx_model.sv ----
// Far-end codec that sends framed samples into the receiver
module codec_tx_model (
  output logic sck,
  output logic ws,
  output logic sd
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 80;
  // Bit clock stands low between frames
  initial begin
    sck = 1'b0;
    ws = 1'b1;
    sd = 1'b0;
  end
  // One 32-clock slot, MSB first, changed while clock is low
  task automatic slot(input logic w, input logic [31:0] d);
    for (int k = 31; k >= 0; k--) begin
      ws = w;
      sd = d[k];
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
  endtask
  // Delay bit, 24-bit sample, junk after the LSB
  task automatic pair(input logic [23:0] l, input logic [23:0] r);
    slot(1'b0, {1'b1, l, 7'h7F});
    slot(1'b1, {1'b0, r, 7'h55});
  endtask
  // Return to left so the last pair is taken, then release data
  task automatic close(input logic w);
    ws = w;
    sd = ~sd;
    #HALF sck = 1'b1;
    #HALF sck = 1'b0;
    sd = ~sd;
  endtask
endmodule

// ---- rx_pair_fifo.v ----
// Eight-entry FIFO of left/right sample pairs
`include "audio_rx_defines.vh"

module rx_pair_fifo (
  input  wire                        core_clk,
  input  wire                        arst_n,
  input  wire                        push,
  input  wire [`RX_PAIR_W-1:0]       push_pair,
  input  wire                        pop,
  output wire [`RX_PAIR_W-1:0]       head_pair,
  output wire                        full,
  output wire                        empty,
  output wire [`RX_FIFO_CNT_W-1:0]   count
);

  reg [`RX_PAIR_W-1:0]     mem_r [0:`RX_FIFO_DEPTH-1];
  reg [`RX_FIFO_PTR_W-1:0] wr_ptr_r;
  reg [`RX_FIFO_PTR_W-1:0] rd_ptr_r;
  reg [`RX_FIFO_CNT_W-1:0] cnt_r;
  wire                     do_push;
  wire                     do_pop;

  // Guard against overflow and underflow
  assign do_push   = push & ~full;
  assign do_pop    = pop & ~empty;
  assign full      = (cnt_r == `RX_FIFO_FULL_CNT);
  assign empty     = (cnt_r == {`RX_FIFO_CNT_W{1'b0}});
  assign count     = cnt_r;
  assign head_pair = mem_r[rd_ptr_r];

  // Storage array, written only on accepted push
  always @(posedge core_clk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= push_pair;
    end
  end

  // Pointers and occupancy
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= {`RX_FIFO_PTR_W{1'b0}};
      rd_ptr_r <= {`RX_FIFO_PTR_W{1'b0}};
      cnt_r    <= {`RX_FIFO_CNT_W{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push & ~do_pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_pop & ~do_push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule

// ---- test_audio_rx_irq.sv ----
// Self-checking bench for the audio receiver
module test_audio_rx_irq;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, arst_n = 0, rx_engine_enable = 0, rx_mclk_external = 1;
  logic sclk_master_sel = 0, sclk_invert = 0, justify_right = 0, data_delay = 1;
  logic ws_polarity = 0, rx_read_mode = 0, compact_size = 0, mono_fifo_select = 0;
  logic channel_select = 0, rx_fifo_req_enable = 0, tx_fifo_req_enable = 0;
  logic tx_write_full_attempt = 0, rx_fifo_rd = 0, rx_fifo_rd_right = 0, int_mclk = 0;
  logic [5:0] sample_bits = 6'h18, slot_bits = 6'h20;
  logic [4:0] rx_limit = 5'h04, tx_limit = 5'h00, tx_fill_level = 5'h00;
  logic [3:0] irq_mask = 4'h0, irq_clear = 4'h0;
  wire rx_master_clock_pin_i, rx_master_clock_pin_o, rx_master_clock_pin_oe_n;
  wire rx_bit_clock_pin_i, rx_bit_clock_pin_o, rx_bit_clock_pin_oe_n, m_sck, m_ws;
  wire rx_ws_pin_i, rx_ws_pin_o, rx_ws_pin_oe_n, rx_data_pin_i, rx_next_is_right;
  wire irq_r, tx_dma_burst_req_r, rx_dma_burst_req_r;
  wire [31:0] rx_fifo_data_r;
  wire [4:0] rx_fill_level;
  wire [3:0] raw_status_r, masked_status_r;
  int n_fail = 0, checks_done = 0;
  // Pin levels from whichever side drives
  assign rx_master_clock_pin_i = rx_master_clock_pin_oe_n ? int_mclk : rx_master_clock_pin_o;
  assign rx_bit_clock_pin_i = rx_bit_clock_pin_oe_n ? m_sck : rx_bit_clock_pin_o;
  assign rx_ws_pin_i = rx_ws_pin_oe_n ? m_ws : rx_ws_pin_o;
  codec_tx_model codec (.sck(m_sck), .ws(m_ws), .sd(rx_data_pin_i));
  audio_rx_irq dut (.*);
  // Core clock and an unrelated master clock source
  always #10 core_clk = ~core_clk;
  initial begin
    #5;
    forever #50 int_mclk = ~int_mclk;
  end
  function automatic logic [23:0] lv(int i);
    return {20'hA_1B2C, 4'(i)};
  endfunction
  function automatic logic [23:0] rv(int i);
    return {4'(i), 20'h3_D4E5};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic right);
    @(posedge core_clk) begin rx_fifo_rd <= 1; rx_fifo_rd_right <= right; end
    @(posedge core_clk) rx_fifo_rd <= 0;
    #1;
  endtask
  // Transmit service request, its boundary and DMA gating
  task automatic t_tx_svc;
    @(posedge core_clk) begin tx_limit <= 5'h08; tx_fill_level <= 5'h07; end
    @(posedge core_clk) begin irq_mask <= 4'h1; tx_fifo_req_enable <= 1; end
    tick(2);
    chk("tx_raw", raw_status_r[0], 1);
    chk("tx_irq", irq_r, 1);
    chk("tx_dma", tx_dma_burst_req_r, 1);
    @(posedge core_clk) tx_fill_level <= 5'h08;
    tick(2);
    chk("tx_raw_lim", raw_status_r[0], 0);
    @(posedge core_clk) begin tx_fill_level <= 5'h07; tx_fifo_req_enable <= 0; end
    tick(2);
    chk("tx_dma_off", tx_dma_burst_req_r, 0);
    chk("tx_raw_off", raw_status_r[0], 0);
    @(posedge core_clk) tx_fill_level <= 5'h08;
  endtask
  // Sticky write error, masking, set winning over clear
  task automatic t_tx_err;
    @(posedge core_clk) begin irq_mask <= 4'h2; tx_write_full_attempt <= 1; end
    @(posedge core_clk) tx_write_full_attempt <= 0;
    tick(4);
    chk("werr", raw_status_r[1], 1);
    chk("werr_irq", irq_r, 1);
    @(posedge core_clk) irq_mask <= 4'h0;
    tick(2);
    chk("werr_msk", masked_status_r, 4'h0);
    chk("werr_raw", raw_status_r[1], 1);
    @(posedge core_clk) begin tx_write_full_attempt <= 1; irq_clear <= 4'h2; end
    @(posedge core_clk) begin tx_write_full_attempt <= 0; irq_clear <= 4'h0; end
    #1 chk("werr_win", raw_status_r[1], 1);
    @(posedge core_clk) irq_clear <= 4'h2;
    @(posedge core_clk) irq_clear <= 4'h0;
    #1 chk("werr_clr", raw_status_r[1], 0);
  endtask
  // Ten pairs into the eight-pair FIFO, then receive service and DMA
  task automatic t_rx_fill;
    @(posedge core_clk) begin rx_engine_enable <= 1; irq_mask <= 4'h4; rx_fifo_req_enable <= 1; end
    tick(4);
    chk("rx_svc0", raw_status_r[2], 0);
    for (int i = 0; i < 10; i++) codec.pair(lv(i), rv(i));
    codec.close(1'b0);
    tick(10);
    chk("lvl_full", rx_fill_level, 5'h10);
    chk("rx_svc", raw_status_r[2], 1);
    chk("rx_dma", rx_dma_burst_req_r, 1);
    @(posedge core_clk) rx_limit <= 5'h10;
    tick(2);
    chk("rx_svc_lim", raw_status_r[2], 0);
  endtask
  // Every read mode, a misordered read and an empty read
  task automatic t_rx_read;
    logic [23:0] l, r;
    rd(0);
    chk("e0l", rx_fifo_data_r, {lv(0), 8'h00});
    chk("nxt_r", rx_next_is_right, 1);
    rd(1);
    chk("e0r", rx_fifo_data_r, {rv(0), 8'h00});
    chk("lvl14", rx_fill_level, 5'h0E);
    rd(1);
    chk("ord_dat", rx_fifo_data_r, {rv(0), 8'h00});
    chk("ord_err", raw_status_r[3], 1);
    chk("ord_lvl", rx_fill_level, 5'h0E);
    @(posedge core_clk) begin irq_clear <= 4'h8; rx_read_mode <= 1; end
    @(posedge core_clk) irq_clear <= 4'h0;
    #1 chk("rerr_clr", raw_status_r[3], 0);
    rd(0);
    l = lv(1);
    r = rv(1);
    chk("c16", rx_fifo_data_r, {r[23:8], l[23:8]});
    @(posedge core_clk) compact_size <= 1;
    rd(0);
    l = lv(2);
    r = rv(2);
    chk("c8", rx_fifo_data_r, {16'h0000, r[23:16], l[23:16]});
    @(posedge core_clk) begin rx_read_mode <= 0; mono_fifo_select <= 1; end
    rd(0);
    chk("mono_l", rx_fifo_data_r, {lv(3), 8'h00});
    @(posedge core_clk) channel_select <= 1;
    rd(0);
    chk("mono_r", rx_fifo_data_r, {rv(4), 8'h00});
    @(posedge core_clk) begin mono_fifo_select <= 0; irq_mask <= 4'h8; end
    for (int i = 5; i < 8; i++) begin
      rd(0);
      chk("el", rx_fifo_data_r, {lv(i), 8'h00});
      rd(1);
      chk("er", rx_fifo_data_r, {rv(i), 8'h00});
    end
    chk("lvl0", rx_fill_level, 5'h00);
    rd(0);
    chk("emp_dat", rx_fifo_data_r, {rv(7), 8'h00});
    chk("emp_irq", irq_r, 1);
  endtask
  // Right-justified pair with word select meaning swapped
  task automatic t_rx_rjust;
    @(posedge core_clk) begin justify_right <= 1; ws_polarity <= 1; end
    tick(2);
    codec.slot(1'b1, {8'hA5, lv(9)});
    codec.slot(1'b0, {8'h5A, rv(9)});
    codec.close(1'b1);
    tick(10);
    chk("rj_lvl", rx_fill_level, 5'h02);
    rd(0);
    chk("rj_l", rx_fifo_data_r, {lv(9), 8'h00});
    rd(1);
    chk("rj_r", rx_fifo_data_r, {rv(9), 8'h00});
  endtask
  // Internal master clock divided down to the bit clock and word select
  task automatic t_master;
    int n_sck = 0;
    int n_ws = 0;
    int n_mck = 0;
    logic p_sck, p_ws, p_mck;
    @(posedge core_clk) begin rx_mclk_external <= 0; sclk_master_sel <= 1; end
    tick(40);
    chk("mclk_oe", rx_master_clock_pin_oe_n, 0);
    chk("sck_oe", rx_bit_clock_pin_oe_n, 0);
    chk("ws_oe", rx_ws_pin_oe_n, 0);
    p_sck = rx_bit_clock_pin_o;
    p_ws = rx_ws_pin_o;
    p_mck = rx_master_clock_pin_o;
    repeat (1280) begin
      tick(1);
      if (rx_bit_clock_pin_o && !p_sck) n_sck++;
      if (rx_ws_pin_o != p_ws) n_ws++;
      if (rx_master_clock_pin_o && !p_mck) n_mck++;
      p_sck = rx_bit_clock_pin_o;
      p_ws = rx_ws_pin_o;
      p_mck = rx_master_clock_pin_o;
    end
    chk("sck_rate", (n_sck >= 63 && n_sck <= 65), 1);
    chk("ws_rate", n_ws, 2);
    chk("mck_rate", (n_mck >= 255 && n_mck <= 257), 1);
    @(posedge core_clk) begin sclk_master_sel <= 0; sclk_invert <= 1; end
    tick(2);
    chk("sck_inv", rx_bit_clock_pin_o, 1);
    chk("sck_rel", rx_bit_clock_pin_oe_n, 1);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1;
    tick(2);
    chk("rst_stat", raw_status_r, 4'h0);
    chk("rst_irq", irq_r, 0);
    t_tx_svc;
    t_tx_err;
    t_rx_fill;
    t_rx_read;
    t_rx_rjust;
    t_master;
    end_sim;
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    end_sim;
  end
endmodule
bind audio_rx_irq audio_rx_irq_chk chk_i (.*);
